// file: rtl/adcdc_pkg.sv
// Purpose: shared constants for the daisy-chain readout block
// Assumes: 16-bit result, one extra leading edge in the busy variant
// Notes: counts are in shift-clock falling edges
`default_nettype none
package adcdc_pkg;
  localparam int RES_W = 16;
  localparam int CNT_W = 5;
  localparam int SYNC_W = 5;
  // falling edges spent on the busy bit before data starts
  localparam logic [4:0] BUSY_SKIP = 5'h01;
  // edge count at which the own word is exhausted (no-busy variant)
  localparam logic [4:0] OWN_LAST = 5'h0F;
  localparam logic [4:0] CNT_MAX = 5'h11;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [4:0] CNT_RST = 5'h00;
  // busy indicator is active low on the chain line
  localparam logic BUSY_ON = 1'b0;
  localparam logic BUSY_OFF = 1'b1;
  localparam logic OUT_RST = 1'b0;
  typedef enum logic [1:0] {
    ADCDC_IDLE,
    ADCDC_CONV,
    ADCDC_WAIT,
    ADCDC_READ
  } adcdc_state_t;
endpackage
`default_nettype wire

// file: rtl/adcdc_sync.sv
// Purpose: two-flop level synchroniser, a few bits side by side
// Assumes: each bit is an independent level
// Notes: first stage feeds only the second stage
`default_nettype none
module adcdc_sync (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // levels in and out
  input wire logic [adcdc_pkg::SYNC_W-1:0] async_in,
  output logic [adcdc_pkg::SYNC_W-1:0] sync_out
);
  logic [adcdc_pkg::SYNC_W-1:0] meta_r;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_r <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// file: rtl/adcdc_readout.sv
// Purpose: daisy-chain serial readout of one 16-bit converter
// Assumes: host drives conv_trigger and shift_clk; core gives conv_done
// Notes: shift register runs on shift_clk falls, pin logic on core_clk
//
// Notes on behaviour
// R1: trigger rise with chain_in low selects chain mode.
// R2: host pulses the trigger low then high to start a conversion.
// R3: shift clock low at trigger rise selects the no-busy variant.
// R4: shift clock high at trigger rise selects the busy variant.
// R5: in chain mode chain_out is always driven.
// R6: chain_in and trigger both low force chain_out low.
// R7: first device in a chain keeps chain_in low.
// R8: no-busy: after conversion the result MSB appears on chain_out.
// R9: remaining bits shift out, one per following falling shift edge.
// R10: every falling shift edge loads chain_in into the shift register.
// R11: host gives 16 edges per device, MSB first, in no-busy variant.
// R12: board may tie chain_in to the trigger to select chain mode.
// R13: busy shown only when own conversion done and upstream busy seen.
// R14: host starts readout only after busy reaches it.
// R15: busy variant: first edge passes no data; host gives 16N+1 edges.
// R16: mode and variant re-sampled at every trigger rise, then held.
`default_nettype none
module adcdc_readout (
  // core clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // link pins
  input wire logic shift_clk,
  input wire logic conv_trigger,
  input wire logic chain_in,
  output logic chain_out,
  output logic chain_out_oe,
  // converter core
  input wire logic conv_done,
  input wire logic [adcdc_pkg::RES_W-1:0] conv_result,
  output logic conv_start,
  // status
  output logic chain_mode,
  output logic busy_variant
);
  // link domain
  logic [adcdc_pkg::RES_W-1:0] link_sh_r;
  logic link_tgl_r;
  // core domain
  logic [adcdc_pkg::SYNC_W-1:0] sync_q;
  logic trig_s;
  logic chain_s;
  logic sclk_s;
  logic sh_msb_s;
  logic tgl_s;
  logic trig_d_r;
  logic chain_d_r;
  logic sclk_d_r;
  logic tgl_d_r;
  logic trig_rise;
  logic shift_fall;
  logic [2:0] warm_r;
  adcdc_pkg::adcdc_state_t state_r;
  adcdc_pkg::adcdc_state_t state_nxt;
  logic [adcdc_pkg::RES_W-1:0] result_r;
  logic [adcdc_pkg::CNT_W-1:0] cnt_r;
  logic out_nxt;
  logic oe_nxt;

  // bit of the held result that goes out after 'pos' data edges
  function automatic logic result_bit(
    input logic [adcdc_pkg::RES_W-1:0] word,
    input logic [adcdc_pkg::CNT_W-1:0] pos
  );
    logic [adcdc_pkg::CNT_W-1:0] idx;
    idx = adcdc_pkg::OWN_LAST - pos;
    result_bit = word[idx[3:0]];
  endfunction

  // shift register: chain_in comes from upstream on the same clock
  always_ff @(negedge shift_clk or negedge resetn)
  begin
    if (!resetn)
      link_sh_r <= adcdc_pkg::RESULT_RST;
    else
      link_sh_r <= {link_sh_r[adcdc_pkg::RES_W-2:0], chain_in}; // R10
  end

  // every fall is reported to the core as a toggle
  always_ff @(negedge shift_clk or negedge resetn)
  begin
    if (!resetn)
      link_tgl_r <= 1'b0;
    else
      link_tgl_r <= ~link_tgl_r;
  end

  adcdc_sync u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .async_in({link_tgl_r, link_sh_r[adcdc_pkg::RES_W-1], shift_clk,
      chain_in, conv_trigger}),
    .sync_out(sync_q)
  );

  assign trig_s = sync_q[0];
  assign chain_s = sync_q[1];
  assign sclk_s = sync_q[2];
  assign sh_msb_s = sync_q[3];
  assign tgl_s = sync_q[4];
  assign trig_rise = trig_s & ~trig_d_r & warm_r[2];
  assign shift_fall = tgl_s ^ tgl_d_r;

  // sync stages come out of reset at zero, not at the pin idle levels;
  // without this an idle-high trigger looks like a rise after reset
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      warm_r <= 3'h0;
    else
      warm_r <= {warm_r[1:0], 1'b1};
  end

  // one-cycle history; chain_in is judged as it stood before the rise,
  // so tying it to the trigger still reads low
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      trig_d_r <= 1'b0;
      chain_d_r <= 1'b1;
      sclk_d_r <= 1'b0;
      tgl_d_r <= 1'b0;
    end
    else
    begin
      trig_d_r <= trig_s;
      chain_d_r <= chain_s;
      sclk_d_r <= sclk_s;
      tgl_d_r <= tgl_s;
    end
  end

  // mode selection held until the next rise
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      chain_mode <= 1'b0;
      busy_variant <= 1'b0;
    end
    else if (trig_rise)
    begin
      chain_mode <= ~chain_d_r; // R1 R12 R16
      busy_variant <= sclk_d_r; // R3 R4 R16
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      adcdc_pkg::ADCDC_CONV:
        if (conv_done)
          state_nxt = busy_variant ? adcdc_pkg::ADCDC_WAIT
            : adcdc_pkg::ADCDC_READ;
      adcdc_pkg::ADCDC_WAIT:
        if (chain_s == adcdc_pkg::BUSY_ON)
          state_nxt = adcdc_pkg::ADCDC_READ; // R13
      adcdc_pkg::ADCDC_IDLE,
      adcdc_pkg::ADCDC_READ:
        state_nxt = state_r;
      default:
        state_nxt = adcdc_pkg::ADCDC_IDLE;
    endcase
    // a new rise always overrides whatever was in progress: CONV in chain mode, IDLE otherwise
    if (trig_rise)
      state_nxt = chain_d_r ? adcdc_pkg::ADCDC_IDLE
        : adcdc_pkg::ADCDC_CONV; // R1 R16
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      state_r <= adcdc_pkg::ADCDC_IDLE;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      conv_start <= 1'b0;
    else
      conv_start <= trig_rise & ~chain_d_r;
  end

  // result held for the whole readout
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      result_r <= adcdc_pkg::RESULT_RST;
    else if (state_r == adcdc_pkg::ADCDC_CONV && conv_done)
      result_r <= conv_result;
  end

  // falling edges seen since readout began; saturates
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      cnt_r <= adcdc_pkg::CNT_RST;
    else if (state_r != adcdc_pkg::ADCDC_READ)
      cnt_r <= adcdc_pkg::CNT_RST;
    else if (shift_fall && cnt_r != adcdc_pkg::CNT_MAX)
      cnt_r <= cnt_r + 5'h01; // R9
  end

  // once the own word is out, the line follows the shift register head,
  // which is upstream data delayed by sixteen edges
  always_comb
  begin
    out_nxt = adcdc_pkg::OUT_RST;
    case (state_r)
      adcdc_pkg::ADCDC_IDLE:
        out_nxt = adcdc_pkg::OUT_RST;
      adcdc_pkg::ADCDC_CONV:
        out_nxt = busy_variant ? adcdc_pkg::BUSY_OFF : adcdc_pkg::OUT_RST;
      adcdc_pkg::ADCDC_WAIT:
        out_nxt = adcdc_pkg::BUSY_OFF; // R13
      adcdc_pkg::ADCDC_READ:
        if (busy_variant)
        begin
          if (cnt_r == adcdc_pkg::CNT_RST)
            out_nxt = adcdc_pkg::BUSY_ON; // R13
          else if (cnt_r <= adcdc_pkg::OWN_LAST + adcdc_pkg::BUSY_SKIP)
            out_nxt = result_bit(result_r,
              cnt_r - adcdc_pkg::BUSY_SKIP); // R15
          else
            out_nxt = sh_msb_s; // R10
        end
        else
        begin
          if (cnt_r <= adcdc_pkg::OWN_LAST)
            out_nxt = result_bit(result_r, cnt_r); // R8 R9
          else
            out_nxt = sh_msb_s; // R10
        end
      default:
        out_nxt = adcdc_pkg::OUT_RST;
    endcase
    if (!trig_s && !chain_s && warm_r[1])
      out_nxt = 1'b0; // R6
    oe_nxt = chain_mode | (~trig_s & ~chain_s & warm_r[1]); // R5 R6
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      chain_out <= adcdc_pkg::OUT_RST;
      chain_out_oe <= 1'b0;
    end
    else
    begin
      chain_out <= out_nxt;
      chain_out_oe <= oe_nxt;
    end
  end
endmodule
`default_nettype wire

// file: tb/adcdc_properties.sv
// Purpose: port timing checks for the daisy-chain readout block
// Assumes: host holds shift_clk and trigger steady around a rise
// Notes: bound to every readout instance
`default_nettype none
module adcdc_checker (
  // clocks and reset
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic shift_clk,
  // pins
  input wire logic conv_trigger,
  input wire logic chain_in,
  input wire logic chain_out,
  input wire logic chain_out_oe,
  // core and status
  input wire logic conv_done,
  input wire logic [adcdc_pkg::RES_W-1:0] conv_result,
  input wire logic conv_start,
  input wire logic chain_mode,
  input wire logic busy_variant
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // five samples cover the two-flop sync plus the output register
  sequence both_low_s;
    (!conv_trigger && !chain_in) [*5];
  endsequence
  sequence nobusy_done_s;
    conv_done && chain_mode && !busy_variant;
  endsequence
  start_mode_a: assert property (conv_start |-> chain_mode)
    else $error("start without chain mode");
  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  var_nobusy_a: assert property (conv_start && !$past(shift_clk, 4)
    |-> !busy_variant)
    else $error("wrong variant for low clock");
  var_busy_a: assert property (conv_start && $past(shift_clk, 4)
    |-> busy_variant)
    else $error("wrong variant for high clock");
  drive_on_a: assert property (chain_mode [*2] |-> chain_out_oe)
    else $error("output released in chain mode");
  low_force_a: assert property (both_low_s
    |-> !chain_out && chain_out_oe)
    else $error("output not forced low");
  // state moves to readout first, the pin register follows a cycle later
  msb_first_a: assert property (nobusy_done_s
    |-> ##2 chain_out == $past(conv_result[15], 2))
    else $error("msb not presented");
  busy_wait_a: assert property (conv_done && busy_variant |=> chain_out)
    else $error("busy shown too early");
  mode_hold_a: assert property ($changed(chain_mode) ||
    $changed(busy_variant) |-> $past(conv_trigger))
    else $error("selection changed without a rise");
endmodule
bind adcdc_readout adcdc_checker u_chk (.core_clk(core_clk),
  .resetn(resetn), .shift_clk(shift_clk), .conv_trigger(conv_trigger),
  .chain_in(chain_in), .chain_out(chain_out), .chain_out_oe(chain_out_oe),
  .conv_done(conv_done), .conv_result(conv_result),
  .conv_start(conv_start), .chain_mode(chain_mode),
  .busy_variant(busy_variant));
`default_nettype wire

// file: tb/adcdc_host.sv
// Purpose: host model driving trigger, shift clock and upstream data
// Assumes: shift clock period 48 ns, standing still between frames
// Notes: samples chain_out just before the next falling edge
`default_nettype none
module adcdc_host (
  // link pins
  output logic shift_clk,
  output logic conv_trigger,
  output logic chain_in,
  input wire logic chain_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    shift_clk = 1'b0;
    conv_trigger = 1'b1;
    chain_in = 1'b0;
  end
  task automatic trig(input logic sc, input logic ci);
    // keep pin changes off the core clock edges
    #3;
    conv_trigger = 1'b0;
    chain_in = ci;
    shift_clk = sc;
    #203;
    conv_trigger = 1'b1;
    #203;
  endtask
  task automatic set_in(input logic b);
    #3;
    chain_in = b;
  endtask
  // got holds what stood on the line just before each falling edge;
  // the pin lags a fall by up to about 40 ns
  task automatic frame(input int n, input logic [31:0] up,
    output logic [31:0] got);
    #3;
    for (int k = 0; k < n; k++)
    begin
      chain_in = up[31-k];
      shift_clk = 1'b1;
      #22;
      got[31-k] = chain_out;
      #2;
      shift_clk = 1'b0;
      #24;
    end
  endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Purpose: self-checking bench for the daisy-chain readout block
// Assumes: host model drives the link, bench plays the converter core
// Notes: expected bits come from a queue model of the shift chain
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, resetn, shift_clk, conv_trigger, chain_in, chain_out;
  logic chain_out_oe, conv_done, conv_start, chain_mode, busy_variant;
  logic [15:0] conv_result;
  int err_total, checked, cyc, starts;
  integer seed = 32'h87f9_a75f;
  adcdc_readout u_dut (.core_clk(core_clk), .resetn(resetn),
    .shift_clk(shift_clk), .conv_trigger(conv_trigger),
    .chain_in(chain_in), .chain_out(chain_out),
    .chain_out_oe(chain_out_oe), .conv_done(conv_done),
    .conv_result(conv_result), .conv_start(conv_start),
    .chain_mode(chain_mode), .busy_variant(busy_variant));
  adcdc_host u_host (.shift_clk(shift_clk), .conv_trigger(conv_trigger),
    .chain_in(chain_in), .chain_out(chain_out));
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic summarize();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  always @(posedge core_clk)
    if (conv_start === 1'b1)
      starts++;
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      summarize();
    end
  end
  initial
  begin : main
    logic [15:0] res;
    logic [31:0] up, got;
    logic q[$];
    int n;
    resetn = 1'b0;
    conv_done = 1'b0;
    conv_result = 16'h0000;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    // refused rise, no-busy, busy, then no-busy again
    for (int m = 0; m < 4; m++)
    begin
      res = 16'($random(seed));
      up = $random(seed);
      u_host.trig(m == 2, m == 0);
      check("mode", chain_mode, m != 0);
      check("variant", busy_variant, m == 2);
      check("oe", chain_out_oe, m != 0);
      if (m == 0)
        continue;
      if (m == 2)
        u_host.set_in(1'b1);
      @(posedge core_clk);
      conv_result <= res;
      conv_done <= 1'b1;
      @(posedge core_clk);
      conv_done <= 1'b0;
      repeat (3) @(posedge core_clk);
      q = {};
      if (m == 2)
      begin
        check("busy_wait", chain_out, 1'b1);
        u_host.set_in(1'b0);
        repeat (6) @(posedge core_clk);
        check("busy_on", chain_out, 1'b0);
        q.push_back(1'b0);
        for (int i = 15; i >= 0; i--)
          q.push_back(res[i]);
        n = 17;
      end
      else
      begin
        check("msb", chain_out, res[15]);
        for (int i = 15; i >= 0; i--)
          q.push_back(res[i]);
        for (int i = 31; i >= 16; i--)
          q.push_back(up[i]);
        n = 32;
      end
      u_host.frame(n, up, got);
      for (int k = 0; k < n; k++)
        check("bit", got[31-k], q.pop_front());
    end
    check("starts", 16'(starts), 16'h0003);
    summarize();
  end
endmodule
`default_nettype wire
